// file: hw/reis_pin_sampler.sv
// sampling flops for the general-purpose pin levels
`timescale 1ns/1ps
module reis_pin_sampler
  import reis_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 pce,
  input  wire logic [PIN_COUNT-1:0] pin_level_in,
  output logic      [PIN_COUNT-1:0] pin_level_bits
);

  // pins are synchronous; one flop keeps the read path short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_bits <= PIN_LEVEL_STATUS_RESET;
    end else if (pce) begin
      pin_level_bits <= pin_level_in;
    end
  end

endmodule : reis_pin_sampler

// file: hw/reis_pkg.sv
// constants and types for the receiver enable and io supply register slice
package reis_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned PIN_COUNT = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] RX_PORT_CTRL_IDX      = 6'h0C;
  localparam logic [IDX_W-1:0] IO_SUPPLY_CONTROL_IDX = 6'h0D;
  localparam logic [IDX_W-1:0] PIN_LEVEL_STATUS_IDX  = 6'h0E;

  // reset values
  localparam logic [REG_W-1:0] RX_PORT_CTRL_RESET      = 8'h07;
  localparam logic [REG_W-1:0] IO_SUPPLY_CONTROL_RESET = 8'h09;
  localparam logic [REG_W-1:0] PIN_LEVEL_STATUS_RESET  = 8'h00;

  // field positions
  localparam int unsigned RX_PORT_A_BIT  = 0;
  localparam int unsigned RX_PORT_B_BIT  = 1;
  localparam int unsigned RX_PORT_C_BIT  = 2;
  localparam int unsigned LEVEL_SEL_BIT  = 7;
  localparam int unsigned OVERRIDE_BIT   = 6;
  localparam int unsigned MODE_MSB       = 5;
  localparam int unsigned MODE_LSB       = 4;
  localparam int unsigned RESERVED_MSB   = 3;

  // supply mode encodings
  localparam logic [1:0] SUPPLY_MODE_1V8 = 2'h0;
  localparam logic [1:0] SUPPLY_MODE_3V3 = 2'h3;

  // io supply control fields as held or as applied
  typedef struct packed {
    logic       level_sel;
    logic       override;
    logic [1:0] mode;
  } reis_io_supply_control_t;

endpackage : reis_pkg

// file: hw/reis_regs.sv
// apb register slice: receiver enables, io supply control, pin status
`timescale 1ns/1ps
module reis_regs
  import reis_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 pce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [DATA_W-1:0]    pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [DATA_W-1:0]    prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 io_level_detect,
  input  wire logic [PIN_COUNT-1:0] pin_level_in,
  output logic                      rx_port_a_enable,
  output logic                      rx_port_b_enable,
  output logic                      rx_port_c_enable,
  output logic                      high_voltage_level_select,
  output logic                      supply_level_override,
  output logic      [1:0]           supply_mode
);

  // decode of one register word
  function automatic logic addr_hits(input logic [ADDR_W-1:0] addr,
                                     input logic [IDX_W-1:0]  idx);
    return addr == {idx, 2'b00};
  endfunction : addr_hits

  logic [2:0]           rx_port_en;
  reis_io_supply_control_t         io_wr;
  reis_io_supply_control_t         io_eff;
  logic [PIN_COUNT-1:0] pin_level_bits;
  logic                 hit_port;
  logic                 hit_io;
  logic                 hit_pin;
  logic                 mapped;
  logic                 wr_en;
  logic                 setup;
  logic [REG_W-1:0]     next_rbyte;
  logic                 capture;
  logic                 rd_loaded;

  // address decode and phase strobes
  assign hit_port = addr_hits(paddr, RX_PORT_CTRL_IDX);
  assign hit_io   = addr_hits(paddr, IO_SUPPLY_CONTROL_IDX);
  assign hit_pin  = addr_hits(paddr, PIN_LEVEL_STATUS_IDX);
  assign mapped   = hit_port | hit_io | hit_pin;
  assign setup    = pce & psel & ~penable;
  // a setup edge lost to a low clock enable is made up in the access phase,
  // otherwise a read would hand back whatever word was fetched before
  assign capture  = setup | (pce & psel & penable & ~rd_loaded);
  // byte lane 0 carries every field; other lanes hold nothing
  assign wr_en    = psel & penable & pready & pwrite & pstrb[0];

  // zero wait states normally; one more after a frozen setup edge
  assign pready  = pce & (~penable | rd_loaded);
  assign pslverr = psel & penable & ~mapped;

  // live pin levels
  reis_pin_sampler u_pin_sampler (
    .pclk           (pclk),
    .presetn        (presetn),
    .pce            (pce),
    .pin_level_in   (pin_level_in),
    .pin_level_bits (pin_level_bits)
  );

  // receiver enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_port_en <= RX_PORT_CTRL_RESET[2:0];
    end else if (wr_en && hit_port) begin
      rx_port_en <= pwdata[2:0];
    end
  end

  // written io supply fields; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_wr.level_sel <= IO_SUPPLY_CONTROL_RESET[LEVEL_SEL_BIT];
      io_wr.override  <= IO_SUPPLY_CONTROL_RESET[OVERRIDE_BIT];
      io_wr.mode      <= IO_SUPPLY_CONTROL_RESET[MODE_MSB:MODE_LSB];
    end else if (wr_en && hit_io) begin
      io_wr.level_sel <= pwdata[LEVEL_SEL_BIT];
      io_wr.override  <= pwdata[OVERRIDE_BIT];
      io_wr.mode      <= pwdata[MODE_MSB:MODE_LSB];
    end
  end

  // applied supply settings: detected level unless overridden
  always_comb begin
    if (io_wr.override) begin
      io_eff = io_wr;
    end else begin
      io_eff.level_sel = io_level_detect;
      io_eff.override  = 1'b0;
      io_eff.mode      = io_level_detect ? SUPPLY_MODE_3V3 : SUPPLY_MODE_1V8;
    end
  end

  assign rx_port_a_enable          = rx_port_en[RX_PORT_A_BIT];
  assign rx_port_b_enable          = rx_port_en[RX_PORT_B_BIT];
  assign rx_port_c_enable          = rx_port_en[RX_PORT_C_BIT];
  assign high_voltage_level_select = io_eff.level_sel;
  assign supply_level_override     = io_wr.override;
  assign supply_mode               = io_eff.mode;

  // read mux; reads show applied values so detection is visible
  always_comb begin
    next_rbyte = '0;
    if (hit_port) begin
      next_rbyte[2:0] = rx_port_en;
    end else if (hit_io) begin
      next_rbyte[LEVEL_SEL_BIT]         = io_eff.level_sel;
      next_rbyte[OVERRIDE_BIT]          = io_wr.override;
      next_rbyte[MODE_MSB:MODE_LSB]     = io_eff.mode;
      next_rbyte[RESERVED_MSB:0]        = '0;
    end else if (hit_pin) begin
      next_rbyte = pin_level_bits;
    end
  end

  // read data captured ahead of the completing edge so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (capture) begin
      prdata <= {{(DATA_W-REG_W){1'b0}}, next_rbyte};
    end
  end

  // set once prdata holds this transfer's word, cleared as the transfer ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_loaded <= 1'b0;
    end else if (pce) begin
      rd_loaded <= psel & ~(penable & pready) & (rd_loaded | capture);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write_port;
    wr_en && hit_port;
  endsequence

  sequence s_write_io_ovr;
    wr_en && hit_io && pwdata[OVERRIDE_BIT];
  endsequence

  sequence s_read_io_auto;
    setup && hit_io && !io_wr.override;
  endsequence

  sequence s_read_pin;
    pce && setup && hit_pin;
  endsequence

  // setup edge frozen, first live access edge right after it
  sequence s_frozen_setup;
    psel && !penable && !pce ##1 psel && penable && pce;
  endsequence

  // completing write whose only meaningful lane is masked off
  sequence s_masked_write;
    psel && penable && pready && pwrite && !pstrb[0];
  endsequence

  a_port_write_lands: assert property (s_write_port |=>
    rx_port_en == $past(pwdata[2:0]))
    else $error("receiver enable did not take written value");

  a_override_write: assert property (s_write_io_ovr |=>
    high_voltage_level_select == $past(pwdata[LEVEL_SEL_BIT]) &&
    supply_mode == $past(pwdata[MODE_MSB:MODE_LSB]))
    else $error("override write not applied to outputs");

  a_detect_drives: assert property (!io_wr.override |->
    high_voltage_level_select == io_level_detect &&
    supply_mode == {2{io_level_detect}})
    else $error("detected level not driving supply controls");

  a_level_output: assert property (io_wr.override |->
    high_voltage_level_select == io_wr.level_sel)
    else $error("level select output differs from written bit");

  a_auto_readback: assert property (s_read_io_auto |=>
    prdata[LEVEL_SEL_BIT] == $past(io_level_detect) &&
    prdata[MODE_MSB:MODE_LSB] == {2{$past(io_level_detect)}})
    else $error("read of io control did not show detected level");

  a_reserved_zero: assert property (setup && hit_io |=>
    prdata[RESERVED_MSB:0] == '0 && prdata[DATA_W-1:REG_W] == '0)
    else $error("reserved io control bits not zero");

  a_pin_status: assert property (pce ##1 s_read_pin |=>
    prdata[PIN_COUNT-1:0] == $past(pin_level_in, 2))
    else $error("pin status read does not match sampled pins");

  a_freeze_hold: assert property (!pce |=>
    $stable(rx_port_en) && $stable(io_wr) && $stable(prdata) &&
    $stable(pin_level_bits))
    else $error("state changed while clock enable low");

  a_strobe_masked: assert property (s_masked_write |=>
    $stable(rx_port_en) && $stable(io_wr))
    else $error("write with lane 0 strobe low changed a register");

  a_status_readonly: assert property (wr_en && hit_pin |=>
    pin_level_bits == $past(pin_level_in))
    else $error("write to pin status disturbed sampled levels");

  a_unmapped_read: assert property (capture && !mapped |=>
    prdata == '0)
    else $error("read of unmapped address returned data");

  a_frozen_setup_wait: assert property (s_frozen_setup |->
    !pready)
    else $error("access after frozen setup ended before data was fetched");

endmodule : reis_regs

// file: tb/tb.sv
// self-checking bench for the receiver enable and io supply register slice
`timescale 1ns/1ps
module tb
  import reis_pkg::*;
;
  logic                 pclk, presetn, pce, psel, penable, pwrite, io_level_detect;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata, prdata, rd;
  logic [3:0]           pstrb;
  logic                 pready, pslverr, err, en_a, en_b, en_c, lvl, ovr;
  logic [1:0]           mode;
  logic [PIN_COUNT-1:0] pins;
  int                   miscompares, check_count;

  reis_regs uut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_level_detect(io_level_detect),
    .pin_level_in(pins), .rx_port_a_enable(en_a), .rx_port_b_enable(en_b),
    .rx_port_c_enable(en_c), .high_voltage_level_select(lvl),
    .supply_level_override(ovr), .supply_mode(mode));

  // 20 MHz register clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        miscompares++;
        $display("unexpected at %0t: no pready", $time);
        wrap_up();
      end
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic t_reset();
    apb(1'b0, 8'h30, 8'h00); chk(rd, 32'h0000_0007);
    chk({en_c, en_b, en_a}, 3'h7);
    apb(1'b0, 8'h34, 8'h00); chk(rd, 32'h0000_0000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_enables();
    apb(1'b1, 8'h30, 8'h05); chk({en_c, en_b, en_a}, 3'h5);
    apb(1'b0, 8'h30, 8'h00); chk(rd, 32'h0000_0005);
    apb(1'b1, 8'h30, 8'h02); chk({en_c, en_b, en_a}, 3'h2);
    pstrb <= 4'he;
    apb(1'b1, 8'h30, 8'h07); chk({en_c, en_b, en_a}, 3'h2);
    pstrb <= 4'hf;
    $display("receiver enables done");
  endtask : t_enables

  task automatic t_supply();
    io_level_detect <= 1'b1;
    apb(1'b1, 8'h34, 8'h0f); chk({lvl, ovr, mode}, 4'hb);
    apb(1'b0, 8'h34, 8'h00); chk(rd, 32'h0000_00b0);
    apb(1'b1, 8'h34, 8'h40); chk({lvl, ovr, mode}, 4'h4);
    apb(1'b0, 8'h34, 8'h00); chk(rd, 32'h0000_0040);
    io_level_detect <= 1'b0;
    apb(1'b1, 8'h34, 8'hf0); chk({lvl, ovr, mode}, 4'hf);
    apb(1'b0, 8'h34, 8'h00); chk(rd, 32'h0000_00f0);
    apb(1'b1, 8'h34, 8'h00); chk({lvl, ovr, mode}, 4'h0);
    $display("io supply control done");
  endtask : t_supply

  // clock enable low over setup and early access: nothing moves, master waits
  task automatic t_freeze();
    fork
      apb(1'b1, 8'h30, 8'h01);
      begin
        pce <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(pready, 1'b0);
        chk({en_c, en_b, en_a}, 3'h2);
        pce <= 1'b1;
      end
    join
    chk({en_c, en_b, en_a}, 3'h1);
    fork
      apb(1'b0, 8'h34, 8'h00);
      begin
        pce <= 1'b0;
        @(posedge pclk);
        pce <= 1'b1;
      end
    join
    chk(rd, 32'h0000_0000);
    $display("clock enable freeze done");
  endtask : t_freeze

  // asymmetric pin patterns so a swapped bit order shows
  task automatic t_pins();
    pins <= 8'h3a;
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h38, 8'h00); chk(rd, 32'h0000_003a);
    apb(1'b1, 8'h38, 8'h3c); chk(err, 1'b0);
    pins <= 8'hc5;
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h38, 8'h00); chk(rd, 32'h0000_00c5);
    apb(1'b0, 8'h3c, 8'h00); chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("pin status done");
  endtask : t_pins

  // main sequence; reset held for 8 cycles
  initial begin
    miscompares = 0;
    check_count = 0;
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    io_level_detect = 1'b0;
    pins = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_enables();
    t_supply();
    t_freeze();
    t_pins();
    wrap_up();
  end
endmodule : tb
